//--- common/ccs_pkg.sv
package ccs_pkg;

  // clock and prescaler timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int TICK_PERIOD_NS  = 1000000;
  localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LOCK_IDLE_S     = 60;
  localparam int LOCK_HOLD_S     = 3;
  localparam int TICKS_PER_S     = 1000;
  localparam logic [15:0] LOCK_IDLE_TICKS = 16'(LOCK_IDLE_S * TICKS_PER_S);
  localparam logic [15:0] LOCK_HOLD_TICKS = 16'(LOCK_HOLD_S * TICKS_PER_S);

  // channel counts
  localparam int NUM_CHANNELS = 11;
  localparam int NUM_TIMECODE = 3;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;

  // control register field positions
  localparam int CTRL_AUTO_BIT  = 0;
  localparam int CTRL_FORCE_BIT = 1;

  // interrupt status field positions
  localparam int IRQ_SEL_BIT    = 0;
  localparam int IRQ_REFUSE_BIT = 1;
  localparam int IRQ_FAULTP_BIT = 2;
  localparam int IRQ_FAULTB_BIT = 3;
  localparam int IRQ_LOCK_BIT   = 4;
  localparam int IRQ_WIDTH      = 5;

  // reset values
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RST = 5'h00;

  // settings kept across power cycles
  typedef struct packed {
    logic remote;
    logic lock;
    logic force_manual_mode;
    logic auto_en;
    logic backup;
  } ccs_nv_t;

  // factory settings: primary source, auto changeover on
  localparam ccs_nv_t NV_FACTORY = '{remote: 1'b0, lock: 1'b0, force_manual_mode: 1'b0,
                                     auto_en: 1'b1, backup: 1'b0};

  // asynchronous panel and status pins
  typedef struct packed {
    logic key_src;
    logic key_lock;
    logic key_ctrl;
    logic key_clear;
    logic fault_p;
    logic fault_b;
    logic primary_alarm_in;
    logic backup_alarm_in;
  } ccs_pins_t;

  // hold-to-toggle states of the lock key
  typedef enum logic [1:0] {
    HOLD_IDLE  = 2'b00,
    HOLD_COUNT = 2'b01,
    HOLD_DONE  = 2'b10
  } ccs_hold_t;

endpackage

//--- core/ccs_ctrl.sv
// Operation
// - key lock engages after one minute without any panel key press
// - while locked, only the local/remote key and the lock key hold act; other keys are ignored
// - holding the lock key three seconds toggles the key lock
// - at power-on all settings and the source selection are restored
// - one source selection applies to all signal and time-code channels
// - each of eleven channels outputs primary or backup per the selection
// - each of three time-code channels outputs primary or backup per selection
// - each source key press requests a toggle, which may be refused
// - a source indicator shows which source is on the outputs
// - with no saved settings the selection starts at primary
// - alarm inputs pass to alarm outputs regardless of selection
// - normal mode refuses a manual switch onto a faulted source; the code allows it when the current source is faulted too
// - forced manual mode ignores faults only while auto changeover is off
// - auto changeover leaves the selected source when it is faulted; the code stays when the other source is faulted too
// - fault latches hold until the clear key is pressed with good input
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module ccs_ctrl #(
  parameter int TICK_CYCLES = ccs_pkg::TICK_CYCLES,
  parameter int NCH         = ccs_pkg::NUM_CHANNELS,
  parameter int NTC         = ccs_pkg::NUM_TIMECODE
) (
  // clock and reset
  input  wire logic                           i_clock,
  input  wire logic                           i_rst,
  // register port
  input  wire logic [7:0]                     i_addr,
  input  wire logic [31:0]                    i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [31:0]                    o_rdata,
  output logic                                o_irq,
  // panel keys, fault detectors and alarms (asynchronous)
  input  wire ccs_pkg::ccs_pins_t             i_pins,
  // saved settings
  input  wire logic                           i_nv_valid,
  input  wire ccs_pkg::ccs_nv_t               i_nv,
  output ccs_pkg::ccs_nv_t                    o_nv,
  // signal paths
  input  wire logic [NCH-1:0]                 i_chan_primary,
  input  wire logic [NCH-1:0]                 i_chan_backup,
  output logic      [NCH-1:0]                 o_channel_output,
  input  wire logic [NTC-1:0]                 i_tc_primary,
  input  wire logic [NTC-1:0]                 i_tc_backup,
  output logic      [NTC-1:0]                 o_tc_output,
  // indicators
  output logic                                o_source_backup,
  output logic                                o_fault_primary,
  output logic                                o_fault_backup,
  output logic                                o_key_lock,
  output logic                                o_remote,
  output logic                                o_primary_alarm_out,
  output logic                                o_backup_alarm_out
);

  // pin synchronisers and agreed values
  ccs_pkg::ccs_pins_t pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
  logic [3:0]         key_prev_r;
  // settings and state
  ccs_pkg::ccs_nv_t   set_r;
  logic               restore_pend_r;
  logic               fault_p_r, fault_b_r;
  logic [ccs_pkg::IRQ_WIDTH-1:0] irq_stat_r, irq_mask_r;
  // prescaler and timers
  logic [31:0]        presc_r;
  logic               tick_r;
  logic [15:0]        idle_r, hold_r;
  ccs_pkg::ccs_hold_t hold_st_r, hold_st_nxt;

  // agreed pin value: a bit changes once stages two and three match
  wire [7:0] pin_agree = ~(pin_s2_r ^ pin_s3_r);
  wire [7:0] pin_nxt   = (pin_s2_r & pin_agree) | (pin_r & ~pin_agree);

  always_ff @(posedge i_clock) begin
    pin_s1_r <= i_pins;
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
    if (i_rst) begin
      pin_r      <= '0;
      key_prev_r <= 4'h0;
    end else begin
      pin_r      <= ccs_pkg::ccs_pins_t'(pin_nxt);
      key_prev_r <= {pin_r.key_src, pin_r.key_lock, pin_r.key_ctrl, pin_r.key_clear};
    end
  end

  // key press edges and lock gating
  wire press_src   = pin_r.key_src & ~key_prev_r[3];
  wire press_lock  = pin_r.key_lock & ~key_prev_r[2];
  wire press_ctrl  = pin_r.key_ctrl & ~key_prev_r[1];
  wire press_clear = pin_r.key_clear & ~key_prev_r[0];
  wire any_press   = press_src | press_lock | press_ctrl | press_clear;
  wire src_ok      = press_src & ~set_r.lock;
  wire clear_ok    = press_clear & ~set_r.lock;

  // source decision: faulted target refused unless current is faulted too or force_ok is set
  wire cur_fault    = set_r.backup ? fault_b_r : fault_p_r;
  wire other_fault  = set_r.backup ? fault_p_r : fault_b_r;
  wire force_ok     = set_r.force_manual_mode & ~set_r.auto_en;
  wire auto_go      = set_r.auto_en & cur_fault & ~other_fault;
  wire manual_ok    = ~other_fault | cur_fault | force_ok;
  wire manual_go    = src_ok & manual_ok & ~auto_go;
  wire manual_ref   = src_ok & ~manual_ok & ~auto_go;
  wire sel_flip     = auto_go | manual_go;

  // 1 ms prescaler tick
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      presc_r <= 32'h0;
      tick_r  <= 1'b0;
    end else begin
      tick_r  <= (presc_r == 32'(TICK_CYCLES - 1));
      presc_r <= (presc_r == 32'(TICK_CYCLES - 1)) ? 32'h0 : presc_r + 32'h1;
    end
  end

  // inactivity timer, restarted by any press
  wire idle_fire = tick_r & ~set_r.lock & (idle_r == ccs_pkg::LOCK_IDLE_TICKS - 16'h1);
  always_ff @(posedge i_clock) begin
    if (i_rst || any_press || set_r.lock)
      idle_r <= 16'h0;
    else if (tick_r && idle_r != ccs_pkg::LOCK_IDLE_TICKS)
      idle_r <= idle_r + 16'h1;
  end

  // lock key hold-to-toggle machine
  wire hold_fire = (hold_st_r == ccs_pkg::HOLD_COUNT) & pin_r.key_lock & tick_r
                   & (hold_r == ccs_pkg::LOCK_HOLD_TICKS - 16'h1);
  always_comb begin
    hold_st_nxt = hold_st_r;
    unique case (hold_st_r)
      ccs_pkg::HOLD_IDLE:  if (press_lock) hold_st_nxt = ccs_pkg::HOLD_COUNT;
      ccs_pkg::HOLD_COUNT: if (!pin_r.key_lock) hold_st_nxt = ccs_pkg::HOLD_IDLE;
                           else if (hold_fire) hold_st_nxt = ccs_pkg::HOLD_DONE;
      ccs_pkg::HOLD_DONE:  if (!pin_r.key_lock) hold_st_nxt = ccs_pkg::HOLD_IDLE;
      default:             hold_st_nxt = ccs_pkg::HOLD_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      hold_st_r <= ccs_pkg::HOLD_IDLE;
      hold_r    <= 16'h0;
    end else begin
      hold_st_r <= hold_st_nxt;
      if (hold_st_r != ccs_pkg::HOLD_COUNT)
        hold_r <= 16'h0;
      else if (tick_r)
        hold_r <= hold_r + 16'h1;
    end
  end

  // register decode
  wire wr_ctrl = i_wr & (i_addr == ccs_pkg::REG_CTRL);
  wire wr_stat = i_wr & (i_addr == ccs_pkg::REG_IRQ_STAT);
  wire wr_mask = i_wr & (i_addr == ccs_pkg::REG_IRQ_MASK);

  // settings: restore once after reset, then keys, register and changeover
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      set_r          <= ccs_pkg::NV_FACTORY;
      restore_pend_r <= 1'b1;
    end else if (restore_pend_r) begin
      set_r          <= i_nv_valid ? i_nv : ccs_pkg::NV_FACTORY;
      restore_pend_r <= 1'b0;
    end else begin
      if (sel_flip)
        set_r.backup <= ~set_r.backup;
      if (idle_fire || (hold_fire && !set_r.lock))
        set_r.lock <= 1'b1;
      else if (hold_fire)
        set_r.lock <= 1'b0;
      if (press_ctrl)
        set_r.remote <= ~set_r.remote;
      if (wr_ctrl) begin
        set_r.auto_en           <= i_wdata[ccs_pkg::CTRL_AUTO_BIT];
        set_r.force_manual_mode <= i_wdata[ccs_pkg::CTRL_FORCE_BIT];
      end
    end
  end

  // fault latches: raw fault sets, clear key with good input releases
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      fault_p_r <= 1'b0;
      fault_b_r <= 1'b0;
    end else begin
      fault_p_r <= pin_r.fault_p | (fault_p_r & ~clear_ok);
      fault_b_r <= pin_r.fault_b | (fault_b_r & ~clear_ok);
    end
  end

  // interrupt events; a new event wins over a write-one clear
  wire [ccs_pkg::IRQ_WIDTH-1:0] irq_evt;
  assign irq_evt[ccs_pkg::IRQ_SEL_BIT]    = sel_flip & ~restore_pend_r;
  assign irq_evt[ccs_pkg::IRQ_REFUSE_BIT] = manual_ref & ~restore_pend_r;
  assign irq_evt[ccs_pkg::IRQ_FAULTP_BIT] = pin_r.fault_p & ~fault_p_r;
  assign irq_evt[ccs_pkg::IRQ_FAULTB_BIT] = pin_r.fault_b & ~fault_b_r;
  assign irq_evt[ccs_pkg::IRQ_LOCK_BIT]   = (idle_fire | hold_fire) & ~restore_pend_r;
  wire [ccs_pkg::IRQ_WIDTH-1:0] irq_clr = wr_stat ? i_wdata[ccs_pkg::IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irq_stat_r <= '0;
      irq_mask_r <= ccs_pkg::IRQ_MASK_RST;
      o_irq      <= 1'b0;
    end else begin
      irq_stat_r <= irq_evt | (irq_stat_r & ~irq_clr);
      if (wr_mask)
        irq_mask_r <= i_wdata[ccs_pkg::IRQ_WIDTH-1:0];
      o_irq      <= |((irq_evt | (irq_stat_r & ~irq_clr))
                      & (wr_mask ? i_wdata[ccs_pkg::IRQ_WIDTH-1:0] : irq_mask_r));
    end
  end

  // read data mux; unmapped addresses read zero
  wire [31:0] status_word = {25'h0, fault_b_r, fault_p_r, set_r};
  wire [31:0] rd_mux =
    (i_addr == ccs_pkg::REG_CTRL)     ? {30'h0, set_r.force_manual_mode, set_r.auto_en} :
    (i_addr == ccs_pkg::REG_STATUS)   ? status_word :
    (i_addr == ccs_pkg::REG_IRQ_STAT) ? {27'h0, irq_stat_r} :
    (i_addr == ccs_pkg::REG_IRQ_MASK) ? {27'h0, irq_mask_r} : 32'h0;

  always_ff @(posedge i_clock) begin
    if (i_rst)
      o_rdata <= 32'h0;
    else
      o_rdata <= i_rd ? rd_mux : 32'h0;
  end

  // output routing and indicators
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_channel_output    <= '0;
      o_tc_output         <= '0;
      o_source_backup     <= 1'b0;
      o_fault_primary     <= 1'b0;
      o_fault_backup      <= 1'b0;
      o_key_lock          <= 1'b0;
      o_remote            <= 1'b0;
      o_primary_alarm_out <= 1'b0;
      o_backup_alarm_out  <= 1'b0;
      o_nv                <= ccs_pkg::NV_FACTORY;
    end else begin
      o_channel_output    <= set_r.backup ? i_chan_backup : i_chan_primary;
      o_tc_output         <= set_r.backup ? i_tc_backup : i_tc_primary;
      o_source_backup     <= set_r.backup;
      o_fault_primary     <= fault_p_r;
      o_fault_backup      <= fault_b_r;
      o_key_lock          <= set_r.lock;
      o_remote            <= set_r.remote;
      o_primary_alarm_out <= pin_r.primary_alarm_in;
      o_backup_alarm_out  <= pin_r.backup_alarm_in;
      o_nv                <= set_r;
    end
  end

  // checks
  chk_idle_lock: assert property (@(posedge i_clock) disable iff (i_rst)
    (idle_fire && !restore_pend_r) |=> set_r.lock)
    else $error("idle timeout did not engage lock");
  chk_locked_ignore: assert property (@(posedge i_clock) disable iff (i_rst)
    (set_r.lock && press_src && !auto_go && !restore_pend_r) |=> $stable(set_r.backup))
    else $error("source key acted while locked");
  chk_hold_toggle: assert property (@(posedge i_clock) disable iff (i_rst)
    (hold_fire && !restore_pend_r) |=> set_r.lock != $past(set_r.lock))
    else $error("lock key hold did not toggle lock");
  chk_nv_restore: assert property (@(posedge i_clock) disable iff (i_rst)
    (restore_pend_r && i_nv_valid) |=> set_r == $past(i_nv))
    else $error("saved settings not restored");
  chk_factory_sel: assert property (@(posedge i_clock) disable iff (i_rst)
    (restore_pend_r && !i_nv_valid) |=> !set_r.backup)
    else $error("factory selection is not primary");
  chk_chan_route: assert property (@(posedge i_clock) disable iff (i_rst)
    !$past(i_rst) |-> o_channel_output ==
      ($past(set_r.backup) ? $past(i_chan_backup) : $past(i_chan_primary)))
    else $error("channel output from wrong source");
  chk_tc_route: assert property (@(posedge i_clock) disable iff (i_rst)
    !$past(i_rst) |-> o_tc_output ==
      ($past(set_r.backup) ? $past(i_tc_backup) : $past(i_tc_primary)))
    else $error("time code output from wrong source");
  chk_refuse_fault: assert property (@(posedge i_clock) disable iff (i_rst)
    (src_ok && other_fault && !cur_fault && !force_ok && !restore_pend_r)
      |=> $stable(set_r.backup))
    else $error("switched onto faulted source");
  chk_force_manual: assert property (@(posedge i_clock) disable iff (i_rst)
    (src_ok && force_ok && !restore_pend_r) |=> set_r.backup != $past(set_r.backup))
    else $error("forced manual switch refused");
  chk_auto_change: assert property (@(posedge i_clock) disable iff (i_rst)
    (auto_go && !restore_pend_r) |=> set_r.backup != $past(set_r.backup) ##1
      o_source_backup == set_r.backup)
    else $error("auto changeover did not switch");
  chk_fault_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    (fault_p_r && !clear_ok) |=> fault_p_r)
    else $error("fault latch released without clear");

endmodule

//--- dv/ccs_panel_model.sv
`timescale 1ns/100ps
// front panel: holds one key for a set time, then a release gap
module ccs_panel_model (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // key command from the bench
  input  wire logic        i_go,
  input  wire logic [1:0]  i_sel,
  input  wire logic [15:0] i_hold,
  // key levels: 3 source, 2 lock, 1 control, 0 clear
  output logic             o_busy,
  output logic      [3:0]  o_keys
);
  logic [15:0] cnt_r;
  logic [1:0]  sel_r;

  // hold span then eight idle cycles, so every press is released again
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt_r  <= 16'h0000;
      sel_r  <= 2'h0;
      o_busy <= 1'b0;
    end else if (i_go && !o_busy) begin
      cnt_r  <= i_hold + 16'h0008;
      sel_r  <= i_sel;
      o_busy <= 1'b1;
    end else if (o_busy) begin
      cnt_r  <= cnt_r - 16'h0001;
      o_busy <= (cnt_r != 16'h0001);
    end
  end

  // key is pressed only inside the hold span
  assign o_keys = (o_busy && cnt_r > 16'h0008) ? (4'h1 << sel_r) : 4'h0;
endmodule

//--- dv/ccs_ctrl_tb.sv
`timescale 1ns/100ps
module ccs_ctrl_tb;
  // bench signals
  logic              i_clock = 1'b0;
  logic              i_rst   = 1'b1;
  logic [7:0]        addr    = 8'h00;
  logic [31:0]       wdata   = 32'h0;
  logic              wr      = 1'b0;
  logic              rd      = 1'b0;
  logic [31:0]       rdata;
  logic              irq;
  logic              go      = 1'b0;
  logic [1:0]        sel     = 2'h0;
  logic [15:0]       hold    = 16'h0;
  logic              busy;
  logic [3:0]        keys;
  logic [1:0]        fault   = 2'h0;
  logic [1:0]        alarm   = 2'h0;
  logic [1:0]        alarm_o;
  logic              nv_ok   = 1'b0;
  ccs_pkg::ccs_nv_t  nv_in   = '0;
  ccs_pkg::ccs_nv_t  nv_out;
  logic [10:0]       ch_p    = '0;
  logic [10:0]       ch_b    = '0;
  logic [10:0]       ch_o;
  logic [10:0]       pp;
  logic [10:0]       pb;
  logic [2:0]        tc_p    = '0;
  logic [2:0]        tc_b    = '0;
  logic [2:0]        tc_o;
  logic [2:0]        tp;
  logic [2:0]        tk;
  logic              src_b;
  logic              flt_p;
  logic              flt_b;
  logic              lk;
  logic              rm;
  logic              rd_seen = 1'b0;
  logic [31:0]       seed    = 32'h9d56bc14;
  int                a_cnt   = 0;
  int                live    = 0;
  int                n_mismatch = 0;
  int                num_checks = 0;
  logic [31:0]       exp_q[$];

  always #10 i_clock = ~i_clock;

  ccs_ctrl #(.TICK_CYCLES(1)) ccs_ctrl_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_pins({keys, fault, alarm}),
    .i_nv_valid(nv_ok), .i_nv(nv_in), .o_nv(nv_out), .i_chan_primary(ch_p),
    .i_chan_backup(ch_b), .o_channel_output(ch_o), .i_tc_primary(tc_p),
    .i_tc_backup(tc_b), .o_tc_output(tc_o), .o_source_backup(src_b),
    .o_fault_primary(flt_p), .o_fault_backup(flt_b), .o_key_lock(lk), .o_remote(rm),
    .o_primary_alarm_out(alarm_o[1]), .o_backup_alarm_out(alarm_o[0]));

  ccs_panel_model ccs_panel_model_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_go(go), .i_sel(sel), .i_hold(hold),
    .o_busy(busy), .o_keys(keys));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // random source data every cycle, alarm pins every 41 cycles
  always @(posedge i_clock) begin
    seed = xs(seed);
    ch_p <= seed[10:0];
    ch_b <= seed[21:11];
    tc_p <= seed[24:22];
    tc_b <= seed[27:25];
    a_cnt <= (a_cnt == 40) ? 0 : a_cnt + 1;
    if (a_cnt == 40) alarm <= seed[29:28];
  end

  // watch outputs: read data against noted results, paths against the selection
  always @(posedge i_clock) begin
    if (rd_seen) check("rdata", rdata, exp_q.pop_front());
    if (live > 2) begin
      check("chan", {21'h0, ch_o}, {21'h0, src_b ? pb : pp});
      check("tc", {29'h0, tc_o}, {29'h0, src_b ? tk : tp});
      if (a_cnt > 8) check("alarm", {30'h0, alarm_o}, {30'h0, alarm});
    end
    rd_seen <= rd;
    live <= i_rst ? 0 : live + 1;
    pp <= ch_p;
    pb <= ch_b;
    tp <= tc_p;
    tk <= tc_b;
  end

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clock);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge i_clock);
    rd <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask

  task automatic press(input logic [1:0] k, input logic [15:0] h);
    int n;
    n = 0;
    @(posedge i_clock);
    go <= 1'b1;
    sel <= k;
    hold <= h;
    @(posedge i_clock);
    go <= 1'b0;
    do begin
      @(negedge i_clock);
      n++;
    end while (busy && n < 8000);
    if (n >= 8000) n_mismatch++;
  endtask

  task automatic do_reset(input logic v, input ccs_pkg::ccs_nv_t s);
    @(posedge i_clock);
    i_rst <= 1'b1;
    nv_ok <= v;
    nv_in <= s;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask

  // watchdog
  initial begin
    repeat (90000) @(posedge i_clock);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    do_reset(1'b0, '0);
    rd_chk(ccs_pkg::REG_STATUS, 32'h2);
    rd_chk(ccs_pkg::REG_IRQ_MASK, 32'h0);
    rd_chk(8'h10, 32'h0);
    rd_chk(ccs_pkg::REG_CTRL, 32'h1);
    wr_reg(ccs_pkg::REG_IRQ_MASK, 32'h1);
    press(2'd3, 16'd6);
    rd_chk(ccs_pkg::REG_STATUS, 32'h3);
    check("src", {31'h0, src_b}, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    rd_chk(ccs_pkg::REG_IRQ_STAT, 32'h1);
    wr_reg(ccs_pkg::REG_IRQ_STAT, 32'h1f);
    repeat (3) @(posedge i_clock);
    check("irq", {31'h0, irq}, 32'h0);
    // primary faults while backup is on air: switch back is refused
    fault <= 2'b10;
    repeat (10) @(posedge i_clock);
    press(2'd3, 16'd6);
    rd_chk(ccs_pkg::REG_STATUS, 32'h23);
    rd_chk(ccs_pkg::REG_IRQ_STAT, 32'h6);
    fault <= 2'b00;
    repeat (10) @(posedge i_clock);
    rd_chk(ccs_pkg::REG_STATUS, 32'h23);
    check("fault_p", {31'h0, flt_p}, 32'h1);
    press(2'd0, 16'd6);
    rd_chk(ccs_pkg::REG_STATUS, 32'h3);
    check("fault_p", {31'h0, flt_p}, 32'h0);
    fault <= 2'b01;
    repeat (10) @(posedge i_clock);
    rd_chk(ccs_pkg::REG_STATUS, 32'h42);
    check("src", {31'h0, src_b}, 32'h0);
    press(2'd0, 16'd6);
    rd_chk(ccs_pkg::REG_STATUS, 32'h42);
    check("fault_b", {31'h0, flt_b}, 32'h1);
    // forced manual mode with and without auto changeover
    wr_reg(ccs_pkg::REG_CTRL, 32'h3);
    rd_chk(ccs_pkg::REG_CTRL, 32'h3);
    press(2'd3, 16'd6);
    rd_chk(ccs_pkg::REG_STATUS, 32'h46);
    wr_reg(ccs_pkg::REG_CTRL, 32'h2);
    press(2'd3, 16'd6);
    rd_chk(ccs_pkg::REG_STATUS, 32'h45);
    wr_reg(ccs_pkg::REG_CTRL, 32'h1);
    repeat (3) @(posedge i_clock);
    rd_chk(ccs_pkg::REG_STATUS, 32'h42);
    fault <= 2'b00;
    repeat (10) @(posedge i_clock);
    press(2'd0, 16'd6);
    rd_chk(ccs_pkg::REG_STATUS, 32'h2);
    // lock key: short hold does nothing, full hold toggles
    press(2'd2, 16'd2950);
    rd_chk(ccs_pkg::REG_STATUS, 32'h2);
    press(2'd2, 16'd3020);
    rd_chk(ccs_pkg::REG_STATUS, 32'ha);
    check("lock", {31'h0, lk}, 32'h1);
    press(2'd3, 16'd6);
    rd_chk(ccs_pkg::REG_STATUS, 32'ha);
    press(2'd1, 16'd6);
    rd_chk(ccs_pkg::REG_STATUS, 32'h1a);
    check("remote", {31'h0, rm}, 32'h1);
    press(2'd2, 16'd3020);
    rd_chk(ccs_pkg::REG_STATUS, 32'h12);
    check("lock", {31'h0, lk}, 32'h0);
    press(2'd1, 16'd6);
    wr_reg(ccs_pkg::REG_IRQ_STAT, 32'h1f);
    // inactivity after the last press engages the lock
    repeat (59770) @(posedge i_clock);
    rd_chk(ccs_pkg::REG_STATUS, 32'h2);
    repeat (420) @(posedge i_clock);
    rd_chk(ccs_pkg::REG_STATUS, 32'ha);
    rd_chk(ccs_pkg::REG_IRQ_STAT, 32'h10);
    check("lock", {31'h0, lk}, 32'h1);
    // power-on restore of backup source and engaged lock
    do_reset(1'b1, 5'h09);
    rd_chk(ccs_pkg::REG_STATUS, 32'h9);
    rd_chk(ccs_pkg::REG_IRQ_MASK, 32'h0);
    check("nv", {27'h0, nv_out}, 32'h9);
    check("src", {31'h0, src_b}, 32'h1);
    repeat (40) @(posedge i_clock);
    print_verdict();
  end
endmodule
